// file: ext_rst_model.sv
// Outside reset circuitry on the open-drain reset pin
module ext_rst_model
(
   input wire rst_pin_out,
   input wire rst_pin_oe,
   input wire pull_low,
   output wire rst_pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pull-up wins only when neither party drives the pin low
   assign rst_pin_in = (rst_pin_oe && !rst_pin_out) || pull_low ? 1'b0 : 1'b1;
endmodule // ext_rst_model

// file: reset_release_sync.v
// Reset release synchroniser: async assert, synchronous deassert
module reset_release_sync
(
   input wire clk,
   input wire cen,
   input wire raw_rst,
   output wire sys_rst_n
);
   reg [1:0] sync_ff;

   always @(posedge clk or posedge raw_rst)
   begin
      if (raw_rst)
         sync_ff <= 2'h0;
      else if (cen)
         sync_ff <= {sync_ff[0], 1'b1};
   end

   assign sys_rst_n = sync_ff[1];
endmodule // reset_release_sync

// file: reset_source_and_clock_select.v
// Reset collection and system clock select with AHB-Lite registers
//
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`include "rst_clk_defs.vh"

module reset_source_and_clock_select
(
   input wire clk,
   input wire nrst,
   input wire cen,
   input wire supply_monitor_enable_pin,
   input wire supply_low,
   input wire watchdog_expired,
   input wire missing_clock,
   input wire level_detect_comparator,
   input wire conversion_start_input,
   input wire rst_pin_in,
   output wire rst_pin_out,
   output wire rst_pin_oe,
   output wire proc_rst_n,
   output wire watchdog_enable,
   output wire clk_sel_ext,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp
);
   reg [`NSRC-1:0] ctrl_ff;
   reg [`NSRC-1:0] cause_ff;
   reg wd_lock_ff;
   reg por_ff;
   reg clk_sel_ff;
   reg sw_req_ff;
   reg pin_rel_ff;
   reg wr_ph_ff;
   reg [11:0] addr_ff;
   reg [31:0] rdata_ff;
   reg [`NSRC-1:0] nxt_cause;
   wire [`NSRC-1:0] raw_src;
   wire [`NSRC-1:0] en_src;
   wire [`NSRC-1:0] act_src;
   wire any_src;
   wire sys_rst_n;
   wire a_valid;
   wire por_src;

   function [31:0] reg_read;
      input [11:0] a;
      begin
         case (a)
            `OFF_CTRL: reg_read = {25'h0, ctrl_ff};
            `OFF_STAT: reg_read = {22'h0, ~sys_rst_n, por_ff, wd_lock_ff,
               cause_ff};
            `OFF_CLK: reg_read = {31'h0, clk_sel_ff};
            default: reg_read = 32'h0;
         endcase
      end
   endfunction

   assign raw_src[`SRC_MON] = supply_low;
   assign raw_src[`SRC_WDT] = watchdog_expired;
   assign raw_src[`SRC_MCD] = missing_clock;
   assign raw_src[`SRC_CMP] = level_detect_comparator;
   assign raw_src[`SRC_SW] = sw_req_ff;
   assign raw_src[`SRC_CNV] = conversion_start_input;
   // Pin reads low while driven by us too; only outside pulls count.
   // Gated by a flop one cycle behind release, so the pin's own rise
   // after release cannot glitch back into the reset path.
   assign raw_src[`SRC_PIN] = ~rst_pin_in & pin_rel_ff;

   genvar g;
   generate
      for (g = 0; g < `NSRC; g = g + 1)
      begin : gen_en
         if (g == `SRC_MON)
            assign en_src[g] = supply_monitor_enable_pin;
         else if (g == `SRC_PIN)
            assign en_src[g] = 1'b1;
         else if (g == `SRC_WDT)
            assign en_src[g] = ctrl_ff[g] | wd_lock_ff;
         else
            assign en_src[g] = ctrl_ff[g];
      end
   endgenerate

   assign act_src = raw_src & en_src;
   assign any_src = |act_src;
   assign por_src = act_src[`SRC_MON];

   reset_release_sync u_sync
   (
      .clk(clk),
      .cen(cen),
      .raw_rst(any_src | ~nrst),
      .sys_rst_n(sys_rst_n)
   );

   assign proc_rst_n = sys_rst_n;
   // Open-drain style: drive low only while internal reset holds
   assign rst_pin_out = 1'b0;
   assign rst_pin_oe = ~sys_rst_n;
   assign watchdog_enable = ctrl_ff[`SRC_WDT] | wd_lock_ff;
   assign clk_sel_ext = clk_sel_ff;

   assign a_valid = hsel & hready & htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_ff;

   always @*
   begin
      nxt_cause = cause_ff | act_src;
   end

   // Cause bits and lock survive non-power-on resets; nrst clears both, monitor clears lock and reloads cause with act_src
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cause_ff <= {`NSRC{1'b0}};
         wd_lock_ff <= 1'b0;
         por_ff <= 1'b1;
         wr_ph_ff <= 1'b0;
         addr_ff <= 12'h000;
         rdata_ff <= 32'h0;
      end
      else if (cen)
      begin
         wr_ph_ff <= a_valid & hwrite;
         if (a_valid)
            addr_ff <= haddr[11:0];
         rdata_ff <= (a_valid & ~hwrite) ? reg_read(haddr[11:0]) : 32'h0;
         if (por_src)
         begin
            wd_lock_ff <= 1'b0;
            por_ff <= 1'b1;
            cause_ff <= act_src;
         end
         else if (wr_ph_ff && addr_ff == `OFF_STAT)
         begin
            // Write-one-clear, but a new cause in the same cycle still lands
            cause_ff <= (cause_ff & ~hwdata[`NSRC-1:0]) | act_src;
            if (hwdata[`STAT_LOCK])
               wd_lock_ff <= 1'b1;
            if (hwdata[`STAT_POR])
               por_ff <= 1'b0;
         end
         else
            cause_ff <= nxt_cause;
      end
   end

   // Held in reset by the synchronised system reset
   always @(posedge clk or negedge sys_rst_n)
   begin
      if (!sys_rst_n)
      begin
         ctrl_ff <= `CTRL_RST;
         clk_sel_ff <= `CLK_SEL_INT;
         sw_req_ff <= 1'b0;
         pin_rel_ff <= 1'b0;
      end
      else if (cen)
      begin
         pin_rel_ff <= 1'b1;
         if (wr_ph_ff && addr_ff == `OFF_CTRL)
            ctrl_ff <= hwdata[`NSRC-1:0] & `CTRL_MASK;
         if (wr_ph_ff && addr_ff == `OFF_CLK)
            clk_sel_ff <= hwdata[0];
         if (wr_ph_ff && addr_ff == `OFF_SWRST && hwdata[0])
            sw_req_ff <= 1'b1;
      end
   end
endmodule // reset_source_and_clock_select

// file: reset_source_and_clock_select_tb_top.sv
// Testbench for the reset and clock select block
`include "rst_clk_defs.vh"
module reset_source_and_clock_select_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk=0, nrst=0, supply_monitor_enable_pin=0, supply_low=0;
   logic missing_clock=0, hsel=0, hwrite=0, pull_low=0;
   logic [1:0] htrans=0;
   logic [31:0] haddr=0, hwdata=0, r;
   wire rst_pin_in, rst_pin_out, rst_pin_oe, proc_rst_n, hready, hresp;
   wire watchdog_enable, clk_sel_ext;
   wire [31:0] hrdata;
   int failures=0, check_count=0, n, i;
   logic [11:0] ra[7] = '{12'h008, 12'h008, 12'h000, 12'h000, 12'h010,
      12'h010, 12'h000};
   logic rw[7] = '{1, 0, 1, 0, 1, 0, 1};
   logic [31:0] rd[7] = '{1, 0, '1, 0, '1, 0, 0};
   logic [31:0] re[7] = '{0, 1, 0, 32'h3e, 0, 0, 0};
   reset_source_and_clock_select u_reset_source_and_clock_select(.clk,
      .nrst, .cen(1'b1), .supply_monitor_enable_pin, .supply_low,
      .watchdog_expired(1'b0), .missing_clock, .level_detect_comparator(1'b0),
      .conversion_start_input(1'b0), .rst_pin_in, .rst_pin_out, .rst_pin_oe,
      .proc_rst_n, .watchdog_enable, .clk_sel_ext, .hsel, .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout(hready),
      .hresp);
   ext_rst_model u_ext_rst_model(.rst_pin_out, .rst_pin_oe, .pull_low,
      .rst_pin_in);
   initial
   begin
      forever #4 clk = ~clk;
   end
   task stop_test;
      if (failures == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e)
      begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task waitok;
      n = 0;
      while (hready !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 20)
      begin
         failures++;
         stop_test;
      end
   endtask
   task bus(input logic [11:0] a, input logic w, input logic [31:0] d);
      hsel <= 1;
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= w;
      @(posedge clk);
      waitok;
      hsel <= 0;
      htrans <= 0;
      hwdata <= d;
      @(posedge clk);
      waitok;
      r = hrdata;
      chk(hresp, 0);
   endtask
   task rel;
      n = 0;
      while (proc_rst_n !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 20)
      begin
         failures++;
         stop_test;
      end
      @(posedge clk);
   endtask
   initial
   begin
      repeat (6) @(posedge clk);
      nrst <= 1;
      rel;
      chk(clk_sel_ext, 0);
      for (i = 0; i < 7; i++)
      begin
         bus(ra[i], rw[i], rd[i]);
         if (!rw[i]) chk(r, re[i]);
      end
      chk(clk_sel_ext, 1);
      missing_clock <= 1;
      repeat (3) @(posedge clk);
      chk(proc_rst_n, 1);
      bus(`OFF_STAT, 1, 32'h80);
      bus(`OFF_CTRL, 1, 0);
      chk(watchdog_enable, 1);
      bus(`OFF_CTRL, 1, 32'h4);
      repeat (2) @(posedge clk);
      chk(proc_rst_n, 0);
      chk(clk_sel_ext, 0);
      chk(rst_pin_in, 0);
      missing_clock <= 0;
      rel;
      chk(watchdog_enable, 1);
      bus(`OFF_CTRL, 1, 32'h10);
      bus(`OFF_SWRST, 1, 1);
      repeat (2) @(posedge clk);
      chk(proc_rst_n, 0);
      rel;
      pull_low <= 1;
      repeat (2) @(posedge clk);
      chk(proc_rst_n, 0);
      pull_low <= 0;
      rel;
      supply_low <= 1;
      repeat (3) @(posedge clk);
      chk(proc_rst_n, 1);
      supply_monitor_enable_pin <= 1;
      repeat (2) @(posedge clk);
      chk(proc_rst_n, 0);
      supply_low <= 0;
      rel;
      chk(watchdog_enable, 0);
      stop_test;
   end
endmodule // reset_source_and_clock_select_tb_top

// file: rst_clk_chk.sv
// Assertion checker for the reset and clock select block
module rst_clk_chk
(
   input wire clk,
   input wire nrst,
   input wire supply_monitor_enable_pin,
   input wire supply_low,
   input wire rst_pin_in,
   input wire rst_pin_out,
   input wire rst_pin_oe,
   input wire proc_rst_n,
   input wire clk_sel_ext
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_oe_tracks_rst: assert property (rst_pin_oe == !proc_rst_n)
      else $error("pin enable differs from reset");
   a_pin_drives_low: assert property (rst_pin_out == 1'b0)
      else $error("pin driven high");
   a_mon_resets: assert property (supply_low && supply_monitor_enable_pin
      |=> !proc_rst_n) else $error("monitor did not reset");
   a_pin_resets: assert property ($fell(rst_pin_in) && $past(proc_rst_n)
      |-> !proc_rst_n) else $error("pin pull did not reset");
   a_clk_int_rst: assert property (!proc_rst_n ##1 !proc_rst_n
      |-> !clk_sel_ext) else $error("external clock in reset");
   a_rel_sync: assert property ($rose(proc_rst_n) |-> $past(nrst, 2) &&
      !($past(supply_low) && $past(supply_monitor_enable_pin)))
      else $error("early release");
   a_clk_run_only: assert property ($rose(clk_sel_ext) |-> $past(proc_rst_n))
      else $error("clock switched in reset");
   a_rst_out_low: assert property (!proc_rst_n |-> !rst_pin_in)
      else $error("pin not low in reset");
   c_pin: cover property ($fell(rst_pin_in) && $past(proc_rst_n));
   c_ext: cover property (clk_sel_ext);
   c_mon: cover property (supply_low && supply_monitor_enable_pin);
endmodule // rst_clk_chk
bind reset_source_and_clock_select rst_clk_chk u_chk(.clk, .nrst,
   .supply_monitor_enable_pin, .supply_low, .rst_pin_in, .rst_pin_out,
   .rst_pin_oe, .proc_rst_n, .clk_sel_ext);

// file: rst_clk_defs.vh
// Register map, field positions and reset values of the reset and clock block
`ifndef RST_CLK_DEFS_VH
`define RST_CLK_DEFS_VH
`define OFF_CTRL 12'h000
`define OFF_STAT 12'h004
`define OFF_CLK 12'h008
`define OFF_SWRST 12'h00c
// Source bits: enables in ctrl (MON enabled by the pin, PIN always enabled), also cause bits in status
`define SRC_MON 0
`define SRC_WDT 1
`define SRC_MCD 2
`define SRC_CMP 3
`define SRC_SW 4
`define SRC_CNV 5
`define SRC_PIN 6
`define NSRC 7
`define CTRL_RST 7'h00
`define CTRL_MASK 7'h3e
`define STAT_LOCK 7
`define STAT_POR 8
`define STAT_RST_OUT 9
`define CLK_SEL_INT 1'b0
`define SYNC_STAGES 2
`endif
